// [hdl/owp_pkg.sv]
package owp_pkg;

  // register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_BAUD = 5'h08;
  localparam logic [4:0] OFS_TXDATA = 5'h0C;
  localparam logic [4:0] OFS_RXDATA = 5'h10;

  // control register fields
  localparam int CTRL_CLKSEL_LSB = 0;
  localparam int CTRL_EXPECT_SYNC = 2;

  // status register fields
  localparam int ST_ENABLED = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_FRAME_ERR = 2;
  localparam int ST_CONT_ERR = 3;
  localparam int ST_PAR_ERR = 4;
  localparam int ST_SYNC_ERR = 5;
  localparam int ST_BREAK = 6;
  localparam int ST_STATE_LSB = 8;

  // link clock select codes
  localparam logic [1:0] CLKSEL_OFF = 2'h0;
  localparam logic [1:0] CLKSEL_16M = 2'h1;
  localparam logic [1:0] CLKSEL_8M = 2'h2;
  localparam logic [1:0] CLKSEL_4M = 2'h3;
  localparam logic [1:0] CLKSEL_RESET = CLKSEL_4M;

  // link tick divider last-count per select
  localparam logic [1:0] DIV_LAST_16M = 2'h0;
  localparam logic [1:0] DIV_LAST_8M = 2'h1;
  localparam logic [1:0] DIV_LAST_4M = 2'h3;

  // reset pin configuration fuse code that hands the pin to the link
  localparam logic [1:0] RSTPIN_TAKEOVER = 2'h1;

  // framing and synchronisation
  localparam logic [7:0] SYNC_CHAR = 8'h55;
  localparam logic [3:0] FRAME_LAST = 4'hB;
  localparam logic [2:0] SYNC_FALLS_LAST = 3'h4;
  localparam logic [16:0] BAUD_STEP = 17'h00008;
  localparam logic [15:0] MIN_SYNC_COUNT = 16'h0010;
  localparam logic [15:0] MAX_SYNC_COUNT = 16'hFFFF;
  localparam logic [15:0] BAUD_RESET = 16'hFFFF;
  localparam int SYNC_TIMEOUT_DEF = 65536;

  typedef enum logic [2:0] {
    OWP_DISABLED = 3'b000,
    OWP_HOLD_LOW = 3'b001,
    OWP_WAIT_SYNC = 3'b010,
    OWP_SYNC_MEAS = 3'b011,
    OWP_IDLE = 3'b100,
    OWP_RX = 3'b101,
    OWP_TX = 3'b110,
    OWP_ERROR = 3'b111
  } owp_state_e_t;

  // pad control bundle
  typedef struct packed {
    logic pull_en;
    logic in_en;
    logic out_en;
    logic out;
  } owp_pad_t;

  // sticky status flags
  typedef struct packed {
    logic brk_seen;
    logic sync_err;
    logic par_err;
    logic cont_err;
    logic frame_err;
  } owp_flags_t;

  typedef struct packed {
    owp_state_e_t st;
    logic pin;
    logic [1:0] clksel;
    logic sync_pending;
    logic [15:0] baud;
    logic [16:0] tmo;
    logic [15:0] meas;
    logic [2:0] falls;
    logic [3:0] bitn;
    logic [11:0] shf;
    logic all_low;
    logic [3:0] brk_cnt;
    logic [7:0] rxbyte;
    logic rx_valid;
    owp_flags_t flags;
    logic osc_req;
    owp_pad_t pad;
    logic waitreq;
    logic [31:0] rdata;
  } owp_top_state_t;

  typedef struct packed {
    logic [15:0] acc;
    logic stb;
  } owp_baud_state_t;

  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } owp_div_state_t;

endpackage

// [hdl/owp_clk_div.sv]
`timescale 1ns/100ps
module owp_clk_div (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // control
  input wire logic run_in,
  input wire logic [1:0] clksel_in,
  // link clock enable
  output logic tick_out
);

  owp_pkg::owp_div_state_t q, d;

  // last count of the divider for a clock select code
  function automatic logic [1:0] div_last(input logic [1:0] sel);
    unique case (sel)
      owp_pkg::CLKSEL_16M: div_last = owp_pkg::DIV_LAST_16M;
      owp_pkg::CLKSEL_8M: div_last = owp_pkg::DIV_LAST_8M;
      default: div_last = owp_pkg::DIV_LAST_4M;
    endcase
  endfunction

  // one-cycle tick at the selected link rate
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!run_in) begin
      d.cnt = 2'h0;
    end else if (q.cnt >= div_last(clksel_in)) begin
      d.cnt = 2'h0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;

endmodule

// [hdl/owp_baud_gen.sv]
`timescale 1ns/100ps
module owp_baud_gen (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // control
  input wire logic tick_in,
  input wire logic restart_in,
  input wire logic half_in,
  input wire logic [15:0] count_in,
  // bit strobe
  output logic strobe_out
);

  owp_pkg::owp_baud_state_t q, d;
  logic [16:0] sum;

  // fractional counter: eight steps per tick against ticks per eight bits
  always_comb begin
    d = q;
    d.stb = 1'b0;
    sum = {1'b0, q.acc} + owp_pkg::BAUD_STEP;
    if (restart_in) begin
      d.acc = half_in ? {1'b0, count_in[15:1]} : 16'h0000;
    end else if (tick_in) begin
      if (sum >= {1'b0, count_in}) begin
        d.stb = 1'b1;
        d.acc = 16'(sum - {1'b0, count_in});
      end else begin
        d.acc = sum[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign strobe_out = q.stb;

endmodule

// [hdl/owp_phy_top.sv]
// How it works
// - sync character is eight bits, value 0x55, normal frame format
// - measured rate serves both receive and transmit of following bytes
// - no software-writable rate; sampling uses only the measured count
// - transmit rate follows link clock select: 1=16, 2=8, 3=4 MHz default
// - fractional rate counting; receiver tolerates +4.76/-3.61 percent
// - break returns link state to default, clearing errors and lost sync
// - break idle detected; during rx frame error, during tx contention, abort
// - break resets link clock select to the 4 MHz default
// - sync pattern length counted in a 16-bit counter, max 65535
// - valid sync character after disable enables the link
// - sync precedes each new instruction; after repeat only the first; here a sync is expected only after reset, a break or an expect-sync write
// - measured count drives rx clock/data recovery and tx rate
// - on falling edge device holds pin low until oscillator ready, then releases
// - after enabling sync, first instruction accepted without another sync
// - accidental trigger: device disables itself and drops oscillator request
// - fuse code 0x1 takes over pin as input with pull-up
// - while active device owns pull, input and output enables of the pin
// - no sync start within 65536 link ticks after release disables device
// - sync too long (overflow) or too short disables the device
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module owp_phy_top #(
  parameter int unsigned SYNC_TIMEOUT_TICKS = owp_pkg::SYNC_TIMEOUT_DEF
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // link pin and its pad controls
  input wire logic link_pin_in,
  output logic link_pin_out,
  output logic link_pin_oe_out,
  output logic link_pin_pull_en_out,
  output logic link_pin_in_en_out,
  // fuse and oscillator
  input wire logic [1:0] reset_pin_config_in,
  input wire logic osc_ready_in,
  output logic osc_req_out,
  output logic [1:0] link_clock_select_out
);

  owp_pkg::owp_top_state_t q, d;
  logic tick;
  logic strobe;
  logic restart;
  logic half;
  logic fall;
  logic takeover;
  logic bus_go;
  logic tx_req;
  logic [11:0] nx;

  // return to the default link state on a break
  function automatic owp_pkg::owp_top_state_t do_break(input owp_pkg::owp_top_state_t s);
    owp_pkg::owp_top_state_t r;
    r = s;
    r.clksel = owp_pkg::CLKSEL_RESET;
    r.flags = '0;
    r.flags.brk_seen = 1'b1;
    r.sync_pending = 1'b1;
    r.brk_cnt = 4'h0;
    r.st = owp_pkg::OWP_IDLE;
    do_break = r;
  endfunction

  // shut the link down after a bad enable sequence
  function automatic owp_pkg::owp_top_state_t do_disable(input owp_pkg::owp_top_state_t s);
    owp_pkg::owp_top_state_t r;
    r = s;
    r.st = owp_pkg::OWP_DISABLED;
    r.osc_req = 1'b0;
    r.flags.sync_err = 1'b1;
    do_disable = r;
  endfunction

  // link tick at the selected link clock rate
  owp_clk_div u_div (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .run_in(q.osc_req),
    .clksel_in(q.clksel),
    .tick_out(tick)
  );

  // bit strobes from the measured sync count
  owp_baud_gen u_baud (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .tick_in(tick),
    .restart_in(restart),
    .half_in(half),
    .count_in(q.baud),
    .strobe_out(strobe)
  );

  assign fall = q.pin & ~link_pin_in;
  assign takeover = (reset_pin_config_in == owp_pkg::RSTPIN_TAKEOVER);
  assign bus_go = (avs_read_in | avs_write_in) & ~q.waitreq;
  assign nx = {link_pin_in, q.shf[11:1]};

  // next-state logic: bus slave, link sequencer, pad control
  always_comb begin
    d = q;
    d.pin = link_pin_in;
    restart = 1'b0;
    half = 1'b0;
    tx_req = 1'b0;
    // register read: data captured as waitrequest drops
    d.waitreq = 1'b1;
    if ((avs_read_in | avs_write_in) && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata = 32'h0000_0000;
      unique case (avs_address_in)
        owp_pkg::OFS_CTRL: begin
          d.rdata[owp_pkg::CTRL_CLKSEL_LSB +: 2] = q.clksel;
          d.rdata[owp_pkg::CTRL_EXPECT_SYNC] = q.sync_pending;
        end
        owp_pkg::OFS_STATUS: begin
          d.rdata[owp_pkg::ST_ENABLED] = (q.st >= owp_pkg::OWP_IDLE);
          d.rdata[owp_pkg::ST_RX_VALID] = q.rx_valid;
          d.rdata[owp_pkg::ST_FRAME_ERR] = q.flags.frame_err;
          d.rdata[owp_pkg::ST_CONT_ERR] = q.flags.cont_err;
          d.rdata[owp_pkg::ST_PAR_ERR] = q.flags.par_err;
          d.rdata[owp_pkg::ST_SYNC_ERR] = q.flags.sync_err;
          d.rdata[owp_pkg::ST_BREAK] = q.flags.brk_seen;
          d.rdata[owp_pkg::ST_STATE_LSB +: 3] = q.st;
        end
        owp_pkg::OFS_BAUD: d.rdata[15:0] = q.baud;
        owp_pkg::OFS_RXDATA: d.rdata[7:0] = q.rxbyte;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    // register write and read side effects at the accepting edge
    if (bus_go && avs_write_in && avs_byteenable_in[0]) begin
      unique case (avs_address_in)
        owp_pkg::OFS_CTRL: begin
          if (avs_writedata_in[owp_pkg::CTRL_CLKSEL_LSB +: 2] != owp_pkg::CLKSEL_OFF) begin
            d.clksel = avs_writedata_in[owp_pkg::CTRL_CLKSEL_LSB +: 2];
          end
          if (avs_writedata_in[owp_pkg::CTRL_EXPECT_SYNC]) begin
            d.sync_pending = 1'b1;
          end
        end
        owp_pkg::OFS_STATUS: begin
          d.flags.frame_err = q.flags.frame_err & ~avs_writedata_in[owp_pkg::ST_FRAME_ERR];
          d.flags.cont_err = q.flags.cont_err & ~avs_writedata_in[owp_pkg::ST_CONT_ERR];
          d.flags.par_err = q.flags.par_err & ~avs_writedata_in[owp_pkg::ST_PAR_ERR];
          d.flags.sync_err = q.flags.sync_err & ~avs_writedata_in[owp_pkg::ST_SYNC_ERR];
          d.flags.brk_seen = q.flags.brk_seen & ~avs_writedata_in[owp_pkg::ST_BREAK];
        end
        owp_pkg::OFS_TXDATA: tx_req = 1'b1;
        default: ;
      endcase
    end
    if (bus_go && avs_read_in && avs_address_in == owp_pkg::OFS_RXDATA) begin
      d.rx_valid = 1'b0;
    end
    // link sequencer; hardware sets come last so they win over clears
    unique case (q.st)
      owp_pkg::OWP_DISABLED: begin
        d.osc_req = 1'b0;
        if (takeover && fall) begin
          d.st = owp_pkg::OWP_HOLD_LOW;
          d.osc_req = 1'b1;
          d.clksel = owp_pkg::CLKSEL_RESET;
          d.baud = owp_pkg::BAUD_RESET;
        end
      end
      owp_pkg::OWP_HOLD_LOW: begin
        if (osc_ready_in) begin
          d.st = owp_pkg::OWP_WAIT_SYNC;
          d.tmo = 17'h00000;
        end
      end
      owp_pkg::OWP_WAIT_SYNC: begin
        if (fall) begin
          d.st = owp_pkg::OWP_SYNC_MEAS;
          d.meas = 16'h0000;
          d.falls = 3'h0;
          d.brk_cnt = 4'h0;
        end else if (tick) begin
          if (q.tmo >= 17'(SYNC_TIMEOUT_TICKS - 1)) begin
            d = do_disable(d);
          end else begin
            d.tmo = q.tmo + 17'h00001;
          end
        end
      end
      owp_pkg::OWP_SYNC_MEAS: begin
        // a tick on a falling edge still counts, so no tick is lost
        if (tick && q.meas == owp_pkg::MAX_SYNC_COUNT) begin
          d = do_disable(d);
        end else begin
          if (tick) begin
            d.meas = q.meas + 16'h0001;
          end
          if (fall) begin
            // fifth falling edge of 0x55 ends eight bit times
            if (q.falls == owp_pkg::SYNC_FALLS_LAST - 3'h1) begin
              if (d.meas < owp_pkg::MIN_SYNC_COUNT) begin
                d = do_disable(d);
              end else begin
                d.baud = d.meas;
                d.st = owp_pkg::OWP_IDLE;
                d.sync_pending = 1'b0;
              end
            end else begin
              d.falls = q.falls + 3'h1;
            end
          end else if (q.falls == 3'h0 && !link_pin_in && strobe) begin
            // second break of a pair lands here; low bits counted at the old rate
            if (q.brk_cnt == owp_pkg::FRAME_LAST) begin
              d = do_break(d);
            end else begin
              d.brk_cnt = q.brk_cnt + 4'h1;
            end
          end
        end
      end
      owp_pkg::OWP_IDLE: begin
        if (fall && q.sync_pending) begin
          d.st = owp_pkg::OWP_SYNC_MEAS;
          d.meas = 16'h0000;
          d.falls = 3'h0;
          d.brk_cnt = 4'h0;
          restart = 1'b1;
          half = 1'b1;
        end else if (fall) begin
          d.st = owp_pkg::OWP_RX;
          restart = 1'b1;
          half = 1'b1;
          d.bitn = 4'h0;
          d.all_low = 1'b1;
        end else if (tx_req) begin
          d.st = owp_pkg::OWP_TX;
          restart = 1'b1;
          d.bitn = 4'h0;
          d.shf = {2'b11, ^avs_writedata_in[7:0], avs_writedata_in[7:0], 1'b0};
        end
      end
      owp_pkg::OWP_RX: begin
        if (strobe) begin
          d.shf = nx;
          d.all_low = q.all_low & ~link_pin_in;
          d.bitn = q.bitn + 4'h1;
          if (q.bitn == 4'h0 && link_pin_in) begin
            d.st = owp_pkg::OWP_IDLE;
          end else if (q.bitn == owp_pkg::FRAME_LAST) begin
            if (q.all_low && !link_pin_in) begin
              d = do_break(d);
            end else if (!nx[10] || !nx[11]) begin
              d.flags.frame_err = 1'b1;
              d.st = owp_pkg::OWP_ERROR;
            end else if (^nx[9:1]) begin
              d.flags.par_err = 1'b1;
              d.st = owp_pkg::OWP_ERROR;
            end else begin
              d.rxbyte = nx[8:1];
              d.rx_valid = 1'b1;
              d.st = owp_pkg::OWP_IDLE;
            end
          end
        end
      end
      owp_pkg::OWP_TX: begin
        if (strobe) begin
          if (q.shf[0] && !link_pin_in) begin
            d.flags.cont_err = 1'b1;
            d.st = owp_pkg::OWP_ERROR;
          end else if (q.bitn == owp_pkg::FRAME_LAST) begin
            d.st = owp_pkg::OWP_IDLE;
          end else begin
            d.shf = {1'b1, q.shf[11:1]};
            d.bitn = q.bitn + 4'h1;
          end
        end
      end
      owp_pkg::OWP_ERROR: begin
        // only a break is honoured here; low bit periods are counted
        if (fall) begin
          restart = 1'b1;
          half = 1'b1;
          d.brk_cnt = 4'h0;
        end else if (link_pin_in) begin
          d.brk_cnt = 4'h0;
        end else if (strobe) begin
          if (q.brk_cnt == owp_pkg::FRAME_LAST) begin
            d = do_break(d);
          end else begin
            d.brk_cnt = q.brk_cnt + 4'h1;
          end
        end
      end
    endcase
    // pad pull and input enables follow the fuse; output enable follows the next state
    d.pad.pull_en = takeover;
    d.pad.in_en = takeover;
    d.pad.out = 1'b0;
    d.pad.out_en = (d.st == owp_pkg::OWP_HOLD_LOW) || (d.st == owp_pkg::OWP_TX && !d.shf[0]);
  end

  // single state register
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.st <= owp_pkg::OWP_DISABLED;
      q.pin <= 1'b1;
      q.clksel <= owp_pkg::CLKSEL_RESET;
      q.sync_pending <= 1'b1;
      q.baud <= owp_pkg::BAUD_RESET;
      q.waitreq <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign avs_readdata_out = q.rdata;
  assign avs_waitrequest_out = q.waitreq;
  assign link_pin_out = q.pad.out;
  assign link_pin_oe_out = q.pad.out_en;
  assign link_pin_pull_en_out = q.pad.pull_en;
  assign link_pin_in_en_out = q.pad.in_en;
  assign osc_req_out = q.osc_req;
  assign link_clock_select_out = q.clksel;

endmodule

// [tb/owp_phy_props.sv]
`timescale 1ns/100ps
module owp_phy_props #(
  parameter int unsigned SYNC_TIMEOUT_TICKS = owp_pkg::SYNC_TIMEOUT_DEF
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // bus
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  // pin, fuse, oscillator
  input wire logic link_pin_in,
  input wire logic link_pin_oe_out,
  input wire logic link_pin_pull_en_out,
  input wire logic link_pin_in_en_out,
  input wire logic [1:0] reset_pin_config_in,
  input wire logic osc_ready_in,
  input wire logic osc_req_out,
  input wire logic [1:0] link_clock_select_out
);
  localparam int WAIT_LIM = 4 * SYNC_TIMEOUT_TICKS + 16;
  logic armed_q;
  logic [19:0] cnt_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // clocks spent waiting for a sync start after the start-up release
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      armed_q <= 1'b0;
      cnt_q <= 20'h00000;
    end else begin
      if (link_pin_oe_out && !osc_ready_in)
        armed_q <= 1'b1;
      else if (!osc_req_out || (!link_pin_in && !link_pin_oe_out))
        armed_q <= 1'b0;
      cnt_q <= (armed_q && !link_pin_oe_out) ? cnt_q + 20'h00001 : 20'h00000;
    end
  end
  a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  a_wait_one_low: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  a_pull_follow_fuse: assert property ($past(rst_b_in) |->
    {link_pin_pull_en_out, link_pin_in_en_out} == {2{$past(reset_pin_config_in) == owp_pkg::RSTPIN_TAKEOVER}})
    else $error("pad pull or input enable wrong");
  a_hold_until_ready: assert property (link_pin_oe_out && osc_req_out && !osc_ready_in |=> link_pin_oe_out)
    else $error("pin released before oscillator ready");
  a_release_on_ready: assert property (link_pin_oe_out && $rose(osc_ready_in) |=> !link_pin_oe_out)
    else $error("pin not released after ready");
  a_fall_starts_hold: assert property (!osc_req_out && reset_pin_config_in == owp_pkg::RSTPIN_TAKEOVER
    && $fell(link_pin_in) |-> ##[1:3] (link_pin_oe_out && osc_req_out))
    else $error("falling edge did not start enable");
  a_clksel_never_off: assert property (link_clock_select_out != owp_pkg::CLKSEL_OFF)
    else $error("clock select left at zero");
  a_clksel_write: assert property (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
    && avs_address_in == owp_pkg::OFS_CTRL && avs_writedata_in[1:0] != owp_pkg::CLKSEL_OFF
    |-> (link_clock_select_out == avs_writedata_in[1:0]) or (##1 link_clock_select_out == $past(avs_writedata_in[1:0])))
    else $error("clock select write lost");
  a_sync_timeout: assert property (int'(cnt_q) < WAIT_LIM)
    else $error("no disable after sync timeout");
endmodule

bind owp_phy_top owp_phy_props #(.SYNC_TIMEOUT_TICKS(SYNC_TIMEOUT_TICKS)) u_props (
  .ref_clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
  .avs_waitrequest_out, .link_pin_in, .link_pin_oe_out, .link_pin_pull_en_out, .link_pin_in_en_out,
  .reset_pin_config_in, .osc_ready_in, .osc_req_out, .link_clock_select_out
);

// [tb/owp_link_host.sv]
`timescale 1ns/100ps
module owp_link_host (
  // clock
  input wire logic ref_clk_in,
  // line
  input wire logic link_in,
  output logic low_out
);
  int bit_clks = 32;
  initial low_out = 1'b0;
  // pull low or release, then let n edges pass
  task automatic hold(input logic lo, input int n);
    low_out <= lo;
    repeat (n) @(posedge ref_clk_in);
  endtask
  // start, data lsb first, even parity, two stops, at a steady rate
  task automatic send_byte(input logic [7:0] b, input logic bad_par);
    logic [11:0] f;
    f = {2'b11, ^b ^ bad_par, b, 1'b0};
    for (int i = 0; i < 12; i++) hold(~f[i], bit_clks);
  endtask
  // pull low for 300 ns, then let go
  task automatic start_enable();
    hold(1'b1, 3);
    hold(1'b0, 1);
  endtask
  // poll until the device lets the line rise
  task automatic wait_high(output logic ok);
    for (int i = 0; i < 3000 && link_in !== 1'b1; i++) @(posedge ref_clk_in);
    ok = (link_in === 1'b1);
  endtask
  // two breaks back to back so one always lands
  task automatic send_break(input int len);
    repeat (2) begin
      hold(1'b1, len);
      hold(1'b0, 2 * bit_clks);
    end
  endtask
  // catch one frame from the device, sampling mid-bit
  task automatic recv(output logic [11:0] f, output logic ok);
    for (int i = 0; i < 2000 && link_in !== 1'b0; i++) @(posedge ref_clk_in);
    ok = (link_in === 1'b0);
    repeat (bit_clks / 2) @(posedge ref_clk_in);
    for (int i = 0; i < 12; i++) begin
      f[i] = link_in;
      repeat (bit_clks) @(posedge ref_clk_in);
    end
  endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic bus_rd = 1'b0;
  logic bus_wr = 1'b0;
  logic [4:0] bus_addr = 5'h00;
  logic [31:0] bus_wdata = 32'h00000000;
  logic [31:0] rdata;
  logic waitreq, pin_out, pin_oe, pull_en, in_en, osc_req, host_low, ok;
  logic osc_ready = 1'b0;
  logic [1:0] fuse = 2'h0;
  logic [1:0] clksel;
  logic [7:0] b;
  logic [11:0] f;
  logic [63:0] exp_q[$];
  int fails = 0;
  int n_checks = 0;
  int p;
  wire link_wire;

  always #50 ref_clk_in = ~ref_clk_in;
  // open-drain line with pull-up
  assign link_wire = ~host_low & ~(pin_oe & ~pin_out);

  owp_phy_top #(.SYNC_TIMEOUT_TICKS(64)) u_dut (
    .ref_clk_in, .rst_b_in, .avs_address_in(bus_addr), .avs_read_in(bus_rd), .avs_write_in(bus_wr),
    .avs_writedata_in(bus_wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .link_pin_in(link_wire), .link_pin_out(pin_out), .link_pin_oe_out(pin_oe),
    .link_pin_pull_en_out(pull_en), .link_pin_in_en_out(in_en), .reset_pin_config_in(fuse),
    .osc_ready_in(osc_ready), .osc_req_out(osc_req), .link_clock_select_out(clksel)
  );
  owp_link_host u_host (.ref_clk_in, .link_in(link_wire), .low_out(host_low));

  // oldest note against each returned read
  always @(posedge ref_clk_in) begin
    logic [63:0] x;
    if (bus_rd && waitreq === 1'b0) begin
      x = exp_q.pop_front();
      `CHK("readdata", x[31:0], (rdata & x[63:32]))
    end
  end

  task automatic print_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one bus cycle held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk_in);
    bus_addr <= a;
    bus_wr <= w;
    bus_rd <= ~w;
    bus_wdata <= d;
    i = 0;
    do begin
      @(posedge ref_clk_in);
      i++;
    end while (waitreq !== 1'b0 && i < 40);
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    if (waitreq !== 1'b0) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back({m, e});
    bus(1'b0, a, 32'h00000000);
  endtask

  initial begin
    void'($urandom(42992));
    repeat (20) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(posedge ref_clk_in);
    `CHK("clksel", 2'h3, clksel)
    rd(5'h1C, 32'hFFFFFFFF, 32'h00000000);
    bus(1'b1, owp_pkg::OFS_BAUD, 32'h00001234);
    rd(owp_pkg::OFS_BAUD, 32'h0000FFFF, {16'h0000, owp_pkg::BAUD_RESET});
    // each select code, then a refused zero
    for (int c = 1; c < 5; c++) begin
      bus(1'b1, owp_pkg::OFS_CTRL, 32'(c % 4));
      rd(owp_pkg::OFS_CTRL, 32'h00000003, 32'(c == 4 ? 3 : c));
      `CHK("clksel", 2'(c == 4 ? 3 : c), clksel)
    end
    fuse <= owp_pkg::RSTPIN_TAKEOVER;
    repeat (2) @(posedge ref_clk_in);
    `CHK("pad", 2'h3, ({pull_en, in_en}))
    $display("test registers done");
    p = 4 * $urandom_range(6, 10);
    u_host.bit_clks = p;
    u_host.start_enable();
    repeat (5) @(posedge ref_clk_in);
    `CHK("held_low", 3'h3, ({link_wire, pin_oe, osc_req}))
    osc_ready <= 1'b1;
    u_host.wait_high(ok);
    `CHK("released", 1'b1, ok)
    u_host.send_byte(owp_pkg::SYNC_CHAR, 1'b0);
    rd(owp_pkg::OFS_STATUS, 32'h00000001, 32'h00000001);
    $display("test enable done");
    // bytes both ways, one run re-armed by an expected sync
    for (int i = 0; i < 3; i++) begin
      if (i == 1) begin
        bus(1'b1, owp_pkg::OFS_CTRL, 32'h00000007);
        u_host.send_byte(owp_pkg::SYNC_CHAR, 1'b0);
      end
      b = 8'($urandom);
      u_host.send_byte(b, 1'b0);
      rd(owp_pkg::OFS_STATUS, 32'h00000002, 32'h00000002);
      rd(owp_pkg::OFS_RXDATA, 32'h000000FF, {24'h000000, b});
      rd(owp_pkg::OFS_STATUS, 32'h00000002, 32'h00000000);
      b = 8'($urandom);
      bus(1'b1, owp_pkg::OFS_TXDATA, {24'h000000, b});
      u_host.recv(f, ok);
      `CHK("tx_frame", ({1'b1, 2'b11, ^b, b, 1'b0}), ({ok, f}))
    end
    $display("test traffic done");
    u_host.send_byte(b, 1'b1);
    rd(owp_pkg::OFS_STATUS, 32'h00000010, 32'h00000010);
    bus(1'b1, owp_pkg::OFS_CTRL, 32'h00000001);
    @(negedge ref_clk_in);
    `CHK("clksel", 2'h1, clksel)
    u_host.send_break(14 * p);
    `CHK("clksel", 2'h3, clksel)
    rd(owp_pkg::OFS_STATUS, 32'h0000007C, 32'h00000040);
    u_host.send_byte(owp_pkg::SYNC_CHAR, 1'b0);
    u_host.send_byte(b, 1'b0);
    rd(owp_pkg::OFS_RXDATA, 32'h000000FF, {24'h000000, b});
    $display("test break done");
    // start-up faults: no sync at all, then a sync far too short
    for (int k = 0; k < 2; k++) begin
      rst_b_in <= 1'b0;
      osc_ready <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      u_host.start_enable();
      repeat (4) @(posedge ref_clk_in);
      osc_ready <= 1'b1;
      u_host.wait_high(ok);
      u_host.bit_clks = 4;
      if (k == 1) u_host.send_byte(owp_pkg::SYNC_CHAR, 1'b0);
      repeat (300) @(posedge ref_clk_in);
      `CHK("osc_req", 1'b0, osc_req)
      rd(owp_pkg::OFS_STATUS, 32'h00000021, 32'h00000020);
    end
    $display("test startup faults done");
    print_verdict();
  end
endmodule
